// ===== design/acsf_regs.svh
`ifndef ACSF_REGS_SVH
`define ACSF_REGS_SVH
// Result word layout, most significant bit first on the wire
`define ACSF_WORD_W 24
`define ACSF_VALUE_W 18
`define ACSF_VALUE_MSB 23
`define ACSF_RSV_BIT 5
`define ACSF_AUX_MSB 4
`define ACSF_AUX_LSB 3
`define ACSF_TAG_MSB 2
// Reset values
`define ACSF_RESULT_RST 24'h00_0000
`define ACSF_SETUP_RST 8'h00
// Code limits and bipolar mid-scale offset
`define ACSF_CODE_MAX 18'h3_FFFF
`define ACSF_CODE_MIN 18'h0_0000
`define ACSF_BIP_OFS 22'sh02_0000
`define ACSF_HI_LIM 22'sh03_FFFF
// Serial bit counts
`define ACSF_RD_LAST 5'h17
`define ACSF_WR_LAST 5'h07
// Operating modes
`define ACSF_MODE_NORM 2'h0
`define ACSF_MODE_OCAL 2'h1
`define ACSF_MODE_GCAL 2'h2
// Channel tags
`define ACSF_TAG_CAL 3'h7
`define ACSF_TAG_P12 3'h4
`define ACSF_TAG_P56 3'h6
// Setting register indices
`define ACSF_TF1 2'h1
`define ACSF_TF2 2'h2
`define ACSF_TF3 2'h3
`endif

// ===== design/acsf_pkg.sv
package acsf_pkg;
  // One transfer-function setting register
  typedef struct packed {
    logic [2:0] gain;
    logic unipolar;
    logic dac_sign;
    logic [2:0] dac_mag;
  } acsf_setup_s;
  // Settings applied to the running conversion
  typedef struct packed {
    logic [2:0] gain;
    logic unipolar;
    logic dac_sign;
    logic [2:0] dac_mag;
    logic dac_connected;
  } acsf_applied_s;
  // Channel mapping answer
  typedef struct packed {
    logic ok;
    logic [1:0] tf_idx;
    logic [2:0] tag;
  } acsf_chan_s;
  // Serial port states
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_READ,
    SER_WRITE
  } acsf_ser_e;
endpackage

// ===== design/acsf_top.sv
// Functional notes
// - DAC code: sign plus magnitude, zero disconnects
// - Normal mode: inputs map to fixed setting registers
// - Offset cal: select bits pick register; scan uses 3
// - Gain cal: select bits pick register; scan uses 3
// - Result word read-only, writes change nothing
// - Write to result needs eight bits, then idle
// - Shift out value, zero, aux, tag, MSB first
// - Value is offset binary when bipolar, straight binary when unipolar, zeros minimum
// - Out-of-range inputs clamp, never wrap
// - Reserved bit after value always zero
// - Aux bits caught on first falling edge
// - Tag codes: singles 0-3, pairs 4-6, cal 7
// - Polarity bit: 0 bipolar, 1 unipolar
`include "acsf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acsf_top import acsf_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] op_mode_i,
  input wire logic fully_differential_select_i,
  input wire logic [1:0] channel_select_i,
  input wire logic scan_i,
  input wire acsf_setup_s setup_1_i,
  input wire acsf_setup_s setup_2_i,
  input wire acsf_setup_s setup_3_i,
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic signed [19:0] raw_i,
  input wire logic rd_start_i,
  input wire logic wr_start_i,
  input wire logic sclk_i,
  input wire logic aux_input_bit_1_i,
  input wire logic aux_input_bit_0_i,
  output logic dout_o,
  output logic ser_idle_o,
  output acsf_applied_s applied_o,
  output logic [1:0] active_tf_o,
  output logic [2:0] source_channel_tag_o,
  output logic [23:0] conversion_result_o
);
  // Channel to register mapping for one configuration and scan step
  function automatic acsf_chan_s chan_map(input logic [1:0] mode, input logic fully_differential_select,
                                          input logic [1:0] sel, input logic scan,
                                          input logic [2:0] idx);
    acsf_chan_s c;
    logic [2:0] nsig;
    c = '0;
    nsig = fully_differential_select ? 3'h3 : 3'h5;
    if (mode == 2'h3 || (fully_differential_select && sel == 2'h3)) begin
      c.ok = 1'b0;
    end else if (!scan) begin
      c.ok = 1'b1;
      if (fully_differential_select) begin
        c.tf_idx = sel + 2'h1;
        c.tag = `ACSF_TAG_P12 + {1'b0, sel};
      end else begin
        c.tf_idx = sel[1] ? `ACSF_TF2 : `ACSF_TF1;
        c.tag = {1'b0, sel};
      end
      if (mode != `ACSF_MODE_NORM) begin
        c.tag = `ACSF_TAG_CAL;
      end
    end else if (idx < nsig) begin
      c.ok = 1'b1;
      if (fully_differential_select) begin
        c.tf_idx = idx[1:0] + 2'h1;
        c.tag = `ACSF_TAG_P12 + idx;
      end else begin
        c.tf_idx = (idx == 3'h4) ? `ACSF_TF3 : (idx[1] ? `ACSF_TF2 : `ACSF_TF1);
        c.tag = (idx == 3'h4) ? `ACSF_TAG_P56 : idx;
      end
    end else if (mode != `ACSF_MODE_NORM && idx < nsig + 3'h2) begin
      c.ok = 1'b1;
      c.tf_idx = `ACSF_TF3;
      c.tag = `ACSF_TAG_CAL;
    end
    return c;
  endfunction

  // Number of steps in one scan pass
  function automatic logic [2:0] scan_len(input logic [1:0] mode, input logic fully_differential_select);
    return (fully_differential_select ? 3'h3 : 3'h5) + ((mode == `ACSF_MODE_NORM) ? 3'h0 : 3'h2);
  endfunction

  // Map filter output onto an 18-bit code with clamping
  function automatic logic [17:0] to_code(input logic signed [19:0] raw, input logic unip);
    logic signed [21:0] s;
    s = {{2{raw[19]}}, raw};
    s = unip ? (s <<< 1) : (s + `ACSF_BIP_OFS);
    if (s < 0) begin
      return `ACSF_CODE_MIN;
    end else if (s > `ACSF_HI_LIM) begin
      return `ACSF_CODE_MAX;
    end
    return s[17:0];
  endfunction

  // Pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic sclk_last_reg;
  // Mapping and conversion state
  logic [2:0] scan_idx_reg, scan_idx_next;
  acsf_chan_s chan_reg, chan_next;
  acsf_chan_s chan_now;
  acsf_setup_s pick;
  acsf_applied_s applied_reg, applied_next;
  logic [1:0] tf_reg, tf_next;
  logic [2:0] tag_reg, tag_next;
  logic [23:0] result_reg, result_next;
  // Serial port state
  acsf_ser_e ser_reg, ser_next;
  logic [23:0] sh_reg, sh_next;
  logic [4:0] cnt_reg, cnt_next;
  logic dout_reg, dout_next, idle_reg;
  logic fall, rise;

  // Two flops on sclk and aux pins; the first is read only by the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 3'h7;
      pin_sync_reg <= 3'h7;
      sclk_last_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {sclk_i, aux_input_bit_1_i, aux_input_bit_0_i};
      pin_sync_reg <= pin_meta_reg;
      sclk_last_reg <= pin_sync_reg[2];
    end
  end
  assign fall = sclk_last_reg & ~pin_sync_reg[2];
  assign rise = ~sclk_last_reg & pin_sync_reg[2];

  // Pick the mapping; a bad selection keeps the last good one
  always_comb begin
    chan_now = chan_map(op_mode_i, fully_differential_select_i, channel_select_i,
                        scan_i, scan_idx_reg);
    chan_next = chan_now.ok ? chan_now : chan_reg;
    case (chan_next.tf_idx)
      `ACSF_TF2: pick = setup_2_i;
      `ACSF_TF3: pick = setup_3_i;
      default: pick = setup_1_i;
    endcase
  end

  // Conversion bookkeeping: latch settings at start, build word at done
  always_comb begin
    scan_idx_next = scan_idx_reg;
    applied_next = applied_reg;
    tf_next = tf_reg;
    tag_next = tag_reg;
    result_next = result_reg;
    if (conv_start_i) begin
      applied_next = {pick, |pick.dac_mag};
      tf_next = chan_next.tf_idx;
      tag_next = chan_next.tag;
    end
    if (conv_done_i) begin
      // Word: value, zero, aux slot, tag; aux slot filled when read
      result_next = {to_code(raw_i, applied_reg.unipolar), 1'b0, 2'b00, tag_reg};
      if (!scan_i || scan_idx_reg + 3'h1 >= scan_len(op_mode_i, fully_differential_select_i)) begin
        scan_idx_next = 3'h0;
      end else begin
        scan_idx_next = scan_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scan_idx_reg <= 3'h0;
      chan_reg <= {1'b1, `ACSF_TF1, 3'h0};
      applied_reg <= '0;
      tf_reg <= `ACSF_TF1;
      tag_reg <= 3'h0;
      result_reg <= `ACSF_RESULT_RST;
    end else begin
      scan_idx_reg <= scan_idx_next;
      chan_reg <= chan_next;
      applied_reg <= applied_next;
      tf_reg <= tf_next;
      tag_reg <= tag_next;
      result_reg <= result_next;
    end
  end

  // Serial port: reads shift on falling sclk, writes are counted and dropped
  always_comb begin
    ser_next = ser_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    dout_next = dout_reg;
    case (ser_reg)
      SER_IDLE: begin
        cnt_next = 5'h00;
        if (rd_start_i) begin
          ser_next = SER_READ;
          sh_next = result_reg;
          dout_next = result_reg[`ACSF_VALUE_MSB];
        end else if (wr_start_i) begin
          ser_next = SER_WRITE;
        end
      end
      SER_READ: begin
        if (fall) begin
          if (cnt_reg == 5'h00) begin
            sh_next[`ACSF_AUX_MSB:`ACSF_AUX_LSB] = pin_sync_reg[1:0];
          end
          dout_next = sh_next[22];
          sh_next = {sh_next[22:0], 1'b0};
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `ACSF_RD_LAST) begin
            ser_next = SER_IDLE;
          end
        end
      end
      SER_WRITE: begin
        // Incoming bits are discarded; the result word is untouched
        if (rise) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `ACSF_WR_LAST) begin
            ser_next = SER_IDLE;
          end
        end
      end
      default: ser_next = SER_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ser_reg <= SER_IDLE;
      sh_reg <= `ACSF_RESULT_RST;
      cnt_reg <= 5'h00;
      dout_reg <= 1'b0;
      idle_reg <= 1'b1;
    end else begin
      ser_reg <= ser_next;
      idle_reg <= (ser_next == SER_IDLE);
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
    end
  end

  // Outputs straight from flops
  assign dout_o = dout_reg;
  assign ser_idle_o = idle_reg;
  assign applied_o = applied_reg;
  assign active_tf_o = tf_reg;
  assign source_channel_tag_o = tag_reg;
  assign conversion_result_o = result_reg;

  // Checks
  property p_dac_conn;
    @(posedge sys_clk_i) disable iff (rst_i)
    conv_start_i |=> applied_reg.dac_connected == (|$past(pick.dac_mag));
  endproperty
  a_dac_conn: assert property (p_dac_conn) else $error("DAC connect wrong");
  property p_norm_map;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_start_i && !scan_i && op_mode_i == 2'h0 && !fully_differential_select_i)
      |=> tf_reg == ($past(channel_select_i[1]) ? 2'h2 : 2'h1);
  endproperty
  a_norm_map: assert property (p_norm_map) else $error("Normal map wrong");
  property p_ocal_tag;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_start_i && !scan_i && op_mode_i == 2'h1 && chan_now.ok) |=> tag_reg == 3'h7;
  endproperty
  a_ocal_tag: assert property (p_ocal_tag) else $error("Cal tag wrong");
  property p_gcal_scan;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_start_i && scan_i && op_mode_i == 2'h2 && chan_now.ok && chan_now.tag == 3'h7)
      |=> tf_reg == 2'h3;
  endproperty
  a_gcal_scan: assert property (p_gcal_scan) else $error("Scan cal register wrong");
  property p_wr_stable;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ser_reg == SER_WRITE && !conv_done_i) |=> $stable(result_reg);
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("Write altered result");
  property p_wr_len;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ser_reg == SER_WRITE && rise && cnt_reg == 5'h07) |=> ser_idle_o;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("Write not ended at 8 bits");
  property p_msb_first;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ser_idle_o && rd_start_i) |=> dout_o == $past(result_reg[23]) && !ser_idle_o;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not first");
  property p_mid;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_done_i && raw_i == 20'sh0_0000 && !applied_reg.unipolar)
      |=> result_reg[23:6] == 18'h2_0000;
  endproperty
  a_mid: assert property (p_mid) else $error("Bipolar zero not mid code");
  property p_clamp;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_done_i && raw_i < -20'sh2_0000) |=> result_reg[23:6] == 18'h0_0000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("Underrange not clamped");
  property p_rsv;
    @(posedge sys_clk_i) disable iff (rst_i)
    conv_done_i |=> result_reg[5] == 1'b0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved bit set");
  property p_aux;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ser_reg == SER_READ && fall && cnt_reg == 5'h00) |=> sh_reg[5:4] == $past(pin_sync_reg[1:0]);
  endproperty
  a_aux: assert property (p_aux) else $error("Aux bits not caught");
  property p_tag_pair;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_start_i && !scan_i && op_mode_i == 2'h0 && fully_differential_select_i
      && channel_select_i == 2'h1) |=> tag_reg == 3'h5;
  endproperty
  a_tag_pair: assert property (p_tag_pair) else $error("Pair tag wrong");
  property p_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (conv_start_i && op_mode_i == 2'h3) |=> tf_reg == $past(chan_reg.tf_idx);
  endproperty
  a_hold: assert property (p_hold) else $error("Invalid mode changed map");
  property p_latch;
    @(posedge sys_clk_i) disable iff (rst_i)
    conv_start_i |=> applied_reg.gain == $past(pick.gain) ##1 $stable(applied_reg) || $past(conv_start_i);
  endproperty
  a_latch: assert property (p_latch) else $error("Settings not latched");
endmodule
`default_nettype wire

// ===== tb/acsf_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller model: clocks the serial port and holds the aux pins
module acsf_host (
  input wire logic sys_clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic aux_input_bit_1_o,
  output logic aux_input_bit_0_o
);
  // Clock idles high between frames; pins start quiet
  initial begin
    sclk_o = 1'b1;
    aux_input_bit_1_o = 1'b0;
    aux_input_bit_0_o = 1'b0;
  end
  // One slow serial period, long enough for the pin synchronisers
  task automatic half_low();
    sclk_o = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1 sclk_o = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
  endtask
  // Read 24 bits, sampling each bit before the falling edge that moves it
  task automatic read_word(output logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      w[i] = dout_i;
      half_low();
    end
  endtask
  // A write to the result word must be followed by eight clocked bits
  task automatic write_bits(input int n);
    repeat (n) half_low();
  endtask
endmodule
`default_nettype wire

// ===== tb/acsf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module acsf_top_tb import acsf_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] op_mode_i = 2'h0;
  logic fully_differential_select_i = 1'b0;
  logic [1:0] channel_select_i = 2'h0;
  logic scan_i = 1'b0;
  logic conv_start_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic signed [19:0] raw_i = 20'sh0_0000;
  logic rd_start_i = 1'b0;
  logic wr_start_i = 1'b0;
  logic sclk, aux1, aux0, dout_o, ser_idle_o;
  acsf_applied_s applied_o;
  logic [1:0] active_tf_o;
  logic [2:0] source_channel_tag_o;
  logic [23:0] conversion_result_o, word, keep;
  // Distinct settings so a wrong register choice shows; reg 3 has DAC off
  acsf_setup_s su [1:3] = '{8'h21, 8'h5A, 8'hE8};
  int n_fail = 0;
  int tests_run = 0;
  // Rows: mode, fully_differential_select, select, expected register, expected tag (one nibble each)
  logic [19:0] rows [16] = '{20'h0_0010, 20'h0_0111, 20'h0_0222, 20'h0_0323,
    20'h0_1014, 20'h0_1125, 20'h0_1236, 20'h1_0017, 20'h1_0117, 20'h1_0227,
    20'h1_0327, 20'h1_1017, 20'h1_1237, 20'h2_0117, 20'h2_1127, 20'h2_1237};
  // Scan order with calibration pairs appended on register 3
  logic [2:0] stag [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h7};
  logic [1:0] stf [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
  int raws [7] = '{-200000, 0, 200000, -5, -131072, 131072, 131071};
  acsf_top i_acsf_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i),
    .fully_differential_select_i(fully_differential_select_i),
    .channel_select_i(channel_select_i), .scan_i(scan_i), .setup_1_i(su[1]),
    .setup_2_i(su[2]), .setup_3_i(su[3]), .conv_start_i(conv_start_i),
    .conv_done_i(conv_done_i), .raw_i(raw_i), .rd_start_i(rd_start_i),
    .wr_start_i(wr_start_i), .sclk_i(sclk), .aux_input_bit_1_i(aux1),
    .aux_input_bit_0_i(aux0), .dout_o(dout_o), .ser_idle_o(ser_idle_o),
    .applied_o(applied_o), .active_tf_o(active_tf_o),
    .source_channel_tag_o(source_channel_tag_o),
    .conversion_result_o(conversion_result_o));
  acsf_host i_acsf_host (.sys_clk_i(sys_clk_i), .dout_i(dout_o), .sclk_o(sclk),
    .aux_input_bit_1_o(aux1), .aux_input_bit_0_o(aux0));
  // 10 MHz system clock
  always #50 sys_clk_i = ~sys_clk_i;
  // Inputs move a fixed 1 ns after the rising edge
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask
  // Expected code: bipolar offset by mid-scale, unipolar doubled, then clamped
  function automatic logic [17:0] exp_code(input int r, input logic u);
    int c;
    c = u ? r * 2 : r + 131072;
    if (c < 0) c = 0;
    if (c > 262143) c = 262143;
    return c[17:0];
  endfunction
  // Start a conversion and check the latched mapping and settings
  task automatic start_chk(input logic [1:0] tf, input logic [2:0] tag);
    conv_start_i = 1'b1;
    step();
    conv_start_i = 1'b0;
    step();
    `CHK(active_tf_o, tf)
    `CHK(source_channel_tag_o, tag)
    `CHK(applied_o, {su[tf], |su[tf][2:0]})
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog, well beyond the expected run of about 450 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (20) step();
    rst_i = 1'b0;
    step();
    `CHK(ser_idle_o, 1'b1)
    `CHK(active_tf_o, 2'h1)
    `CHK(conversion_result_o, 24'h00_0000)
    repeat (3) step();
    // Select-bit mapping, singles and pairs, in all three modes
    foreach (rows[i]) begin
      {op_mode_i, fully_differential_select_i, channel_select_i} =
        {rows[i][17:16], rows[i][12], rows[i][9:8]};
      start_chk(rows[i][5:4], rows[i][2:0]);
    end
    // Do-not-use selection and reserved mode keep the last mapping
    op_mode_i = 2'h0;
    channel_select_i = 2'h3;
    start_chk(2'h3, 3'h7);
    op_mode_i = 2'h3;
    start_chk(2'h3, 3'h7);
    // Scan through both calibration modes, results saturating at the ends
    fully_differential_select_i = 1'b0;
    scan_i = 1'b1;
    for (int m = 1; m <= 2; m++) begin
      op_mode_i = m[1:0];
      for (int s = 0; s < 7; s++) begin
        start_chk(stf[s], stag[s]);
        raw_i = raws[s][19:0];
        conv_done_i = 1'b1;
        step();
        conv_done_i = 1'b0;
        step();
        `CHK(conversion_result_o, {exp_code(raws[s], su[stf[s]][4]), 3'h0, stag[s]})
      end
    end
    // Serial read: value, zero, aux caught at first fall, tag
    {i_acsf_host.aux_input_bit_1_o, i_acsf_host.aux_input_bit_0_o} = 2'b10;
    repeat (3) step();
    rd_start_i = 1'b1;
    step();
    rd_start_i = 1'b0;
    step();
    i_acsf_host.read_word(word);
    `CHK(word, {18'h3_FFFF, 1'b0, 2'b10, 3'h7})
    `CHK(ser_idle_o, 1'b1)
    // Write to the read-only result: idle only after eight bits, word unchanged
    keep = conversion_result_o;
    wr_start_i = 1'b1;
    step();
    wr_start_i = 1'b0;
    step();
    i_acsf_host.write_bits(7);
    `CHK(ser_idle_o, 1'b0)
    i_acsf_host.write_bits(1);
    `CHK(ser_idle_o, 1'b1)
    `CHK(conversion_result_o, keep)
    tally_and_finish();
  end
endmodule
`default_nettype wire
